// File: hdl/registered_cmd_buffer_parity.sv
// What this block does
// [R01] Cycles with a chip select low check even parity; error output low on mismatch.
// [R02] Parity arrives one cycle late and pairs with the previously registered data.
// [R03] After a single error the error output stays low at least two cycles.
// [R04] Consecutive errors keep the error output low for as long as they last.
// [R05] The gate enable has no say in parity checking; chip selects alone decide.
// [R06] Both chip selects and gate enable high mean low power; error output holds.
// [R07] Error low entering low power stays low through it plus two cycles.
// [R08] Inputs are captured on each clock crossing; otherwise outputs hold.
// [R09] Reset clears all registers, drives data outputs low and error output high.
// [R10] With gate enable high, suspendable outputs update only when a chip select is low.
// [R11] The configuration select picks which inputs are covered by parity.
// [R12] Chip select, termination and clock-enable outputs are redriven every crossing.
`timescale 1ns/1ps
`default_nettype none

module registered_cmd_buffer_parity #(
    parameter int DATA_W = cmd_buffer_pkg::CMD_W
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic config_select_i,
    input wire logic select_gate_enable_i,
    input wire logic chip_select_in_a_i,
    input wire logic chip_select_in_b_i,
    input wire logic [cmd_buffer_pkg::PAIR_W-1:0] termination_ctl_in_i,
    input wire logic [cmd_buffer_pkg::PAIR_W-1:0] clock_enable_in_i,
    input wire logic [DATA_W-1:0] cmd_addr_in_i,
    input wire logic parity_bit_in_i,
    output logic [DATA_W-1:0] cmd_addr_out_o,
    output logic chip_select_out_a_o,
    output logic chip_select_out_b_o,
    output logic [cmd_buffer_pkg::PAIR_W-1:0] termination_ctl_out_o,
    output logic [cmd_buffer_pkg::PAIR_W-1:0] clock_enable_out_o,
    output logic low_power_state_o,
    output logic parity_error_n_o,
    output logic parity_error_oe_n_o
);
    import cmd_buffer_pkg::*;

    // Parity masks cover the first CMD_W inputs only
    if (DATA_W < CMD_W) begin : g_width_check
        $error("DATA_W must be at least CMD_W");
    end

    ctl_bits_t ctl_now;
    logic any_select;
    logic next_lpm;
    logic [DATA_W-1:0] cover_mask;
    chk_stage_t chk_stage;
    err_event_t err_event;
    logic next_mismatch;
    logic err_n;

    // Bundle the control pins of this crossing
    assign ctl_now.chip_select_a = chip_select_in_a_i;
    assign ctl_now.chip_select_b = chip_select_in_b_i;
    assign ctl_now.select_gate_enable = select_gate_enable_i;
    assign ctl_now.termination_ctl = termination_ctl_in_i;
    assign ctl_now.clock_enable = clock_enable_in_i;

    // Check qualifier ignores the gate enable
    assign any_select = !ctl_now.chip_select_a || !ctl_now.chip_select_b; // R05
    assign next_lpm = !any_select && ctl_now.select_gate_enable; // R06

    // Coverage mask picked by configuration select
    always_comb begin
        cover_mask = '0;
        if (config_select_i) begin
            cover_mask[CMD_W-1:0] = COVER_MASK_CFG1; // R11
        end else begin
            cover_mask[CMD_W-1:0] = COVER_MASK_CFG0; // R11
        end
    end

    // Suspendable command and address outputs
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_addr_out_o <= {DATA_W{OUT_RESET}}; // R09
        end else if (!next_lpm) begin
            cmd_addr_out_o <= cmd_addr_in_i; // R08 R10
        end
    end

    // Never-suspended outputs follow every crossing
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chip_select_out_a_o <= OUT_RESET; // R09
            chip_select_out_b_o <= OUT_RESET;
            termination_ctl_out_o <= {PAIR_W{OUT_RESET}};
            clock_enable_out_o <= {PAIR_W{OUT_RESET}};
        end else begin
            chip_select_out_a_o <= ctl_now.chip_select_a; // R12
            chip_select_out_b_o <= ctl_now.chip_select_b; // R12
            termination_ctl_out_o <= ctl_now.termination_ctl; // R12
            clock_enable_out_o <= ctl_now.clock_enable; // R12
        end
    end

    // Low-power indication
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_power_state_o <= OUT_RESET;
        end else begin
            low_power_state_o <= next_lpm; // R06
        end
    end

    // Covered data held one cycle to meet its parity bit
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            chk_stage <= '0; // R09
        end else begin
            chk_stage.checked <= any_select; // R01 R05
            chk_stage.low_power_state <= next_lpm;
            chk_stage.covered <= cmd_addr_in_i[CMD_W-1:0] & cover_mask[CMD_W-1:0]; // R02 R11
        end
    end

    // Even parity over held data and the late parity bit
    assign next_mismatch = (^chk_stage.covered) ^ parity_bit_in_i; // R01 R02

    // Comparison result registered, output moves on the edge after
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            err_event <= '0;
        end else begin
            err_event.checked <= chk_stage.checked;
            err_event.low_power_state <= chk_stage.low_power_state; // R07
            err_event.mismatch <= chk_stage.checked && next_mismatch; // R01
        end
    end

    // Latched error level
    parity_error_latch u_error_latch (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .event_i(err_event),
        .parity_error_n_o(err_n)
    );

    // Open-drain pin: driven only while pulling low
    assign parity_error_n_o = err_n;
    assign parity_error_oe_n_o = err_n;

    sequence s_checked_bad;
        any_select ##1 ((^chk_stage.covered) ^ parity_bit_in_i);
    endsequence

    // Bad parity shows two edges after its data was registered
    a_bad_parity_low: assert property ( // R01
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_checked_bad |-> ##2 !parity_error_n_o
    ) else $error("bad parity not reported two cycles after data");

    // Held data is the masked data of the previous crossing
    a_parity_pairing: assert property ( // R02
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        1'b1 |=> chk_stage.covered == ($past(cmd_addr_in_i[CMD_W-1:0]) & $past(cover_mask[CMD_W-1:0]))
    ) else $error("parity compared against the wrong data");

    // Check qualifier follows the chip selects alone
    a_gate_ignored: assert property ( // R05
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        1'b1 |=> chk_stage.checked == !($past(chip_select_in_a_i) && $past(chip_select_in_b_i))
    ) else $error("check qualifier depends on gate enable");

    // Selected cycles redrive the command and address inputs
    a_selected_update: assert property ( // R10
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        any_select |=> cmd_addr_out_o == $past(cmd_addr_in_i)
    ) else $error("command outputs missed a selected update");

    // Gate enable low redrives the command inputs on every crossing
    a_gate_low_update: assert property ( // R08
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !select_gate_enable_i |=> cmd_addr_out_o == $past(cmd_addr_in_i)
    ) else $error("command outputs held with gate enable low");

    // Low-power flag drops once the condition is gone
    a_lpm_exit: assert property ( // R06
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !next_lpm |=> !low_power_state_o
    ) else $error("low-power flag stuck after exit condition");

    // Suspended cycles hold the command and address outputs
    a_suspend_hold: assert property ( // R10
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        next_lpm |=> $stable(cmd_addr_out_o) && low_power_state_o
    ) else $error("command outputs changed while suspended");

    // Side outputs follow every crossing
    a_side_redrive: assert property ( // R12
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        1'b1 |=> chip_select_out_a_o == $past(chip_select_in_a_i)
            && chip_select_out_b_o == $past(chip_select_in_b_i)
            && termination_ctl_out_o == $past(termination_ctl_in_i)
            && clock_enable_out_o == $past(clock_enable_in_i)
    ) else $error("side outputs not redriven");

    // Pin driver pulls low on the edge after a mismatch
    a_open_drain: assert property ( // R01
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        err_event.mismatch |=> !parity_error_oe_n_o
    ) else $error("open-drain enable not pulling low after mismatch");

    // Error output only falls after a registered mismatch
    a_fall_needs_error: assert property ( // R01
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $fell(parity_error_n_o) |-> $past(err_event.mismatch)
    ) else $error("error output fell without a parity mismatch");

    sequence s_two_errors;
        err_event.mismatch ##1 err_event.mismatch;
    endsequence

    // Back-to-back errors keep the output low past the last one
    a_error_run: assert property ( // R04
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_two_errors |=> !parity_error_n_o [*2]
    ) else $error("error output released during an error run");

    // A low error level entering low power survives the tail
    a_lpm_tail_hold: assert property ( // R07
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        err_event.low_power_state && !parity_error_n_o |=> !parity_error_n_o [*3]
    ) else $error("error output released inside the low-power tail");

endmodule : registered_cmd_buffer_parity

`default_nettype wire

// File: inc/cmd_buffer_pkg.sv
`default_nettype none

package cmd_buffer_pkg;

    // Command and address path width
    localparam int CMD_W = 28;
    // Termination and clock-enable pairs
    localparam int PAIR_W = 2;

    // Parity coverage, bit n-1 stands for input n
    localparam logic [CMD_W-1:0] COVER_MASK_CFG0 = 28'hfff0f5f;
    localparam logic [CMD_W-1:0] COVER_MASK_CFG1 = 28'hfaf0fff;

    // Timing counts in clock cycles
    localparam int PARITY_LAG_CYCLES = 1;
    localparam int MIN_HOLD_CYCLES = 2;
    localparam int LPM_TAIL_CYCLES = 2;
    localparam int HOLD_CNT_W = 2;
    localparam logic [HOLD_CNT_W-1:0] MIN_HOLD_LOAD = 2'h1;
    localparam logic [HOLD_CNT_W-1:0] LPM_TAIL_LOAD = 2'h2;

    // Reset values
    localparam logic ERR_N_RESET = 1'b1;
    localparam logic OUT_RESET = 1'b0;
    localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_RESET = 2'h0;

    // Control inputs seen on one clock crossing
    typedef struct packed {
        logic chip_select_a;
        logic chip_select_b;
        logic select_gate_enable;
        logic [PAIR_W-1:0] termination_ctl;
        logic [PAIR_W-1:0] clock_enable;
    } ctl_bits_t;

    // Data waiting for its parity bit
    typedef struct packed {
        logic checked;
        logic low_power_state;
        logic [CMD_W-1:0] covered;
    } chk_stage_t;

    // Outcome of one parity comparison
    typedef struct packed {
        logic checked;
        logic low_power_state;
        logic mismatch;
    } err_event_t;

endpackage : cmd_buffer_pkg

`default_nettype wire

// File: hdl/parity_error_latch.sv
`timescale 1ns/1ps
`default_nettype none

module parity_error_latch (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire cmd_buffer_pkg::err_event_t event_i,
    output logic parity_error_n_o
);
    import cmd_buffer_pkg::*;

    logic [HOLD_CNT_W-1:0] hold_cnt;

    // Error level with minimum hold and low-power extension
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            parity_error_n_o <= ERR_N_RESET; // R09
            hold_cnt <= HOLD_CNT_RESET;
        end else if (event_i.checked && event_i.mismatch) begin
            parity_error_n_o <= 1'b0; // R01 R04
            hold_cnt <= MIN_HOLD_LOAD; // R03
        end else if (event_i.low_power_state) begin
            // Level frozen, a low level earns a tail after exit
            if (!parity_error_n_o) begin
                hold_cnt <= LPM_TAIL_LOAD; // R07
            end
        end else if (hold_cnt != HOLD_CNT_RESET) begin
            hold_cnt <= hold_cnt - 2'h1; // R03 R07
        end else if (event_i.checked) begin
            parity_error_n_o <= 1'b1; // R01
        end
    end

    // Error seen on a checked cycle shows low on the next edge
    a_err_drives_low: assert property ( // R04
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        event_i.checked && event_i.mismatch |=> !parity_error_n_o
    ) else $error("parity error did not pull the error output low");

    // A falling error output stays low for the next cycle
    a_min_low_hold: assert property ( // R03
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        $fell(parity_error_n_o) |=> !parity_error_n_o
    ) else $error("error output released before two cycles");

    // Low-power cycles freeze the error output
    a_lpm_freeze: assert property ( // R06
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        event_i.low_power_state && !event_i.checked |=> $stable(parity_error_n_o)
    ) else $error("error output changed in low-power mode");

    sequence s_lpm_low_exit;
        event_i.low_power_state && !parity_error_n_o ##1 !event_i.low_power_state;
    endsequence

    // Two more low cycles after low-power ends
    a_lpm_tail: assert property ( // R07
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        s_lpm_low_exit |-> !parity_error_n_o ##1 !parity_error_n_o
    ) else $error("error output released too early after low-power");

    // Good parity with no pending hold releases the output
    a_good_parity_high: assert property ( // R01
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        event_i.checked && !event_i.mismatch && hold_cnt == 2'h0 |=> parity_error_n_o
    ) else $error("error output low after good parity");

endmodule : parity_error_latch

`default_nettype wire

// File: test/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module ctrl_model (
    input wire logic ref_clk_i,
    input wire cmd_buffer_pkg::ctl_bits_t req_ctl_i,
    input wire logic [cmd_buffer_pkg::CMD_W-1:0] req_data_i,
    input wire logic req_cfg_i,
    input wire logic req_bad_i,
    output cmd_buffer_pkg::ctl_bits_t ctl_o,
    output logic [cmd_buffer_pkg::CMD_W-1:0] data_o,
    output logic cfg_o,
    output logic parity_o
);
    import cmd_buffer_pkg::*;
    logic [CMD_W-1:0] last_cov;
    logic last_bad;

    // Idle bus: selects high, parity pulled low
    initial begin
        ctl_o = 7'h60;
        data_o = '0;
        cfg_o = 1'b0;
        parity_o = 1'b0;
        last_cov = '0;
        last_bad = 1'b0;
    end

    // Launch request, parity of previous data one cycle later
    always @(negedge ref_clk_i) begin
        ctl_o <= req_ctl_i;
        data_o <= req_data_i;
        cfg_o <= req_cfg_i;
        last_cov <= req_data_i & (req_cfg_i ? COVER_MASK_CFG1 : COVER_MASK_CFG0);
        last_bad <= req_bad_i;
        parity_o <= (^last_cov) ^ last_bad;
    end
endmodule : ctrl_model

`default_nettype wire

// File: test/registered_cmd_buffer_parity_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module registered_cmd_buffer_parity_tb_top;
    import cmd_buffer_pkg::*;
    logic ref_clk, reset_n, req_cfg, req_bad, cfg, parity, lp, err_n, oe_n, cs_a, cs_b;
    ctl_bits_t req_ctl, ctl;
    logic [CMD_W-1:0] req_data, data, q;
    logic [PAIR_W-1:0] odt, cke;
    logic [CMD_W-1:0] hist_q [0:63];
    logic [8:0] hist_f [0:63];
    int n_steps, n_errors, compares;

    ctrl_model ctrl_u (.ref_clk_i(ref_clk), .req_ctl_i(req_ctl), .req_data_i(req_data), .req_cfg_i(req_cfg),
        .req_bad_i(req_bad), .ctl_o(ctl), .data_o(data), .cfg_o(cfg), .parity_o(parity));

    registered_cmd_buffer_parity dut_u (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .config_select_i(cfg),
        .select_gate_enable_i(ctl.select_gate_enable), .chip_select_in_a_i(ctl.chip_select_a),
        .chip_select_in_b_i(ctl.chip_select_b), .termination_ctl_in_i(ctl.termination_ctl),
        .clock_enable_in_i(ctl.clock_enable), .cmd_addr_in_i(data), .parity_bit_in_i(parity),
        .cmd_addr_out_o(q), .chip_select_out_a_o(cs_a), .chip_select_out_b_o(cs_b), .termination_ctl_out_o(odt),
        .clock_enable_out_o(cke), .low_power_state_o(lp), .parity_error_n_o(err_n), .parity_error_oe_n_o(oe_n));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One request: sel is {select a, select b, gate enable}; low data bits feed odt and cke
    task automatic step(input logic [CMD_W-1:0] d, input logic [2:0] sel, input logic c, input logic b);
        @(posedge ref_clk);
        req_data = d;
        req_ctl = {sel, d[3:0]};
        req_cfg = c;
        req_bad = b;
        @(negedge ref_clk);
        hist_q[n_steps] = q;
        hist_f[n_steps] = {cs_b, err_n, oe_n, lp, cs_a, odt, cke};
        n_steps++;
    endtask : step

    task automatic give_verdict;
        $display("Summary: %0d mismatches in %0d compares", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Watchdog against a hang
    initial begin
        #5000;
        n_errors++;
        give_verdict();
    end

    // Request sequence, then checks on recorded history
    initial begin
        reset_n = 1'b0;
        req_ctl = 7'h60;
        req_data = '0;
        req_cfg = 1'b0;
        req_bad = 1'b0;
        n_steps = 0;
        n_errors = 0;
        compares = 0;
        repeat (5) @(negedge ref_clk);
        check({q, err_n, oe_n, lp}, {28'h0, 3'b110});
        reset_n = 1'b1;
        step(28'h0000005, 3'b010, 1'b0, 1'b0);
        step(28'h0000003, 3'b011, 1'b0, 1'b1);
        for (int i = 2; i < 6; i++) step(28'h0000010 + i, 3'b010, 1'b0, 1'b0);
        for (int i = 6; i < 9; i++) step(28'h0100000 * i, 3'b100, 1'b1, 1'b1);
        for (int i = 9; i < 12; i++) step(28'h0000009, 3'b100, 1'b0, 1'b0);
        step(28'h0abcdef, 3'b110, 1'b0, 1'b1);
        step(28'h0000080, 3'b010, 1'b1, 1'b0);
        step(28'h0000080, 3'b010, 1'b0, 1'b0);
        step(28'h0001000, 3'b010, 1'b0, 1'b0);
        step(28'h0000044, 3'b010, 1'b0, 1'b1);
        for (int i = 17; i < 21; i++) step(28'h0f0f0f0 + i, 3'b111, 1'b0, 1'b0);
        for (int i = 21; i < 30; i++) step(28'h0000006, 3'b100, 1'b0, 1'b0);
        step(28'h0000001, 3'b010, 1'b0, 1'b1);
        for (int i = 31; i < 34; i++) step(28'h0000006, 3'b100, 1'b0, 1'b0);
        check(hist_f[33][7], 1'b0);
        reset_n = 1'b0;
        #1;
        check({q, err_n, oe_n, lp}, {28'h0, 3'b110});
        check(hist_q[1], 28'h0000005);
        check(hist_f[1][3:0], 4'h5);
        check(hist_f[3][7], 1'b1);
        check(hist_f[4][7:6], 2'b00);
        check(hist_f[5][7], 1'b0);
        check(hist_f[7][7], 1'b1);
        for (int i = 9; i < 12; i++) check(hist_f[i][7], 1'b0);
        check(hist_f[14][7], 1'b1);
        check(hist_q[13], 28'h0abcdef);
        for (int i = 15; i < 19; i++) check(hist_f[i][7], 1'b1);
        check(hist_f[18][5], 1'b1);
        check(hist_f[22][5], 1'b0);
        for (int i = 18; i < 22; i++) check(hist_q[i], 28'h0000044);
        check(hist_f[19][4:0], 5'h12);
        check({hist_f[7][8], hist_f[19][8]}, 2'b01);
        for (int i = 19; i < 25; i++) check(hist_f[i][7], 1'b0);
        check(hist_f[28][7], 1'b1);
        check({hist_f[25][7], hist_f[26][7]}, 2'b01);
        give_verdict();
    end
endmodule : registered_cmd_buffer_parity_tb_top

`default_nettype wire
